// ==== logic/dpw_pkg.sv ====
// Shared constants and types for the dual pulse-width pin generator.
`default_nettype none
package dpw_pkg;

   // The clock is 25 MHz. The tick is 266.667 ns, which is three ticks every 800 ns.
   localparam int unsigned CLK_PERIOD_PS = 40000;   // System clock period in picoseconds.
   localparam int unsigned TICK_PS       = 266667;  // Period tick in picoseconds.
   localparam int unsigned TICK_NUM      = 3;       // Ticks per prescaler wrap window.
   // Clock cycles per TICK_NUM ticks, rounded to the nearest whole cycle (20).
   localparam int unsigned TICK_DEN      = (TICK_PS * TICK_NUM + CLK_PERIOD_PS / 2) / CLK_PERIOD_PS;
   localparam logic [4:0]  TICK_STEP     = 5'(TICK_NUM);  // Accumulator step per clock.
   localparam logic [4:0]  TICK_WRAP     = 5'(TICK_DEN);  // Accumulator modulus.
   localparam logic [4:0]  TICK_ACC_RST  = 5'h00;         // Accumulator value after reset.

   // Widths and counts.
   localparam int unsigned ADDR_W = 10;  // Register index width.
   localparam int unsigned DATA_W = 16;  // Register data width.
   localparam int unsigned CTL_W  = 9;   // Stored control bits 8:0.
   localparam int unsigned PER_W  = 12;  // Stored period bits 11:0.
   localparam int unsigned NCH    = 2;   // Number of channels.
   localparam int unsigned NPIN   = 32;  // Number of selectable pins.

   // Register indices, as printed.
   localparam logic [9:0] OFF_CH0_CTL  = 10'h3d8;  // pulse_ch0_control.
   localparam logic [9:0] OFF_CH0_HIGH = 10'h3d9;  // pulse_ch0_high_period.
   localparam logic [9:0] OFF_CH0_LOW  = 10'h3da;  // pulse_ch0_low_period.
   localparam logic [9:0] OFF_CH1_CTL  = 10'h3db;  // pulse_ch1_control.
   localparam logic [9:0] OFF_CH1_HIGH = 10'h3dc;  // pulse_ch1_high_period.
   localparam logic [9:0] OFF_CH1_LOW  = 10'h3dd;  // pulse_ch1_low_period.

   // Control field positions.
   localparam int unsigned CMD_MSB = 8;  // Command field top bit.
   localparam int unsigned CMD_LSB = 6;  // Command field bottom bit.
   localparam int unsigned EN_BIT  = 5;  // Enable bit.
   localparam int unsigned PIN_MSB = 4;  // Pin selector top bit (bottom is 0).

   // Values after reset.
   localparam logic [8:0]  CTL_RST    = 9'h000;   // Idle, disabled, pin zero.
   localparam logic [11:0] PERIOD_RST = 12'h001;  // One tick.

   // Command encodings; 001 to 011 are undefined.
   typedef enum logic [2:0] {
      CMD_IDLE    = 3'b000,
      CMD_LOW     = 3'b100,
      CMD_ONESHOT = 3'b101,
      CMD_RUN     = 3'b110,
      CMD_LOW_ALT = 3'b111
   } dpw_cmd_t;

   // Channel sequencer states.
   typedef enum logic [2:0] {
      ST_HOLD   = 3'b000,
      ST_LOW    = 3'b001,
      ST_SHOT   = 3'b010,
      ST_RUN_HI = 3'b011,
      ST_RUN_LO = 3'b100
   } dpw_state_t;

endpackage : dpw_pkg
`default_nettype wire

// ==== logic/dpw_tick.sv ====
// Fractional prescaler producing one enable pulse per 266.667 ns tick.
`timescale 1ns/10ps
`default_nettype none
module dpw_tick (
   input  wire logic mclk,    // System clock, 25 MHz.
   input  wire logic arst_n,  // Asynchronous reset, active low.
   output var  logic tick     // One-cycle pulse per tick.
);

   // Accumulator and registered tick pulse.
   typedef struct packed {
      logic [4:0] acc;   // Fractional phase accumulator.
      logic       tick;  // Registered tick pulse.
   } dpw_tick_state_t;

   dpw_tick_state_t s_q;  // Current state.
   dpw_tick_state_t s_d;  // Next state.
   logic [5:0]      sum;  // Accumulator plus step, one bit wider.

   // Adding 3 modulo 20 gives three pulses every 20 clocks; the spacing
   // alternates 7,7,6 cycles, which averages exactly one tick period.
   always_comb begin
      sum    = {1'b0, s_q.acc} + {1'b0, dpw_pkg::TICK_STEP};
      s_d    = s_q;
      s_d.tick = 1'b0;
      if (sum >= {1'b0, dpw_pkg::TICK_WRAP}) begin
         s_d.acc  = 5'(sum - {1'b0, dpw_pkg::TICK_WRAP});
         s_d.tick = 1'b1;
      end else begin
         s_d.acc = sum[4:0];
      end
   end

   // State register.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{acc: dpw_pkg::TICK_ACC_RST, tick: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign tick = s_q.tick;

endmodule : dpw_tick
`default_nettype wire

// ==== logic/dpw_phase.sv ====
// Phase length counter: counts a loaded number of ticks and pulses when done.
`timescale 1ns/10ps
`default_nettype none
module dpw_phase (
   input  wire logic        mclk,      // System clock.
   input  wire logic        arst_n,    // Asynchronous reset, active low.
   input  wire logic        load,      // Start a new phase this cycle.
   input  wire logic [11:0] load_val,  // Phase length in ticks.
   input  wire logic        tick,      // Prescaler tick pulse.
   output var  logic        done       // One-cycle pulse at phase end.
);

   // Counter state.
   typedef struct packed {
      logic [11:0] cnt;   // Ticks still to run.
      logic        busy;  // Phase in progress.
      logic        done;  // Registered end pulse.
   } dpw_phase_state_t;

   dpw_phase_state_t s_q;  // Current state.
   dpw_phase_state_t s_d;  // Next state.

   // A load restarts the count even mid-phase; the first tick may come
   // anywhere inside the first tick window, so a phase lasts between
   // N-1 and N tick periods plus a few clocks of pipeline.
   always_comb begin
      s_d      = s_q;
      s_d.done = 1'b0;
      if (load) begin
         s_d.cnt  = load_val;
         s_d.busy = 1'b1;
      end else if (s_q.busy && tick) begin
         if (s_q.cnt <= 12'h001) begin
            s_d.busy = 1'b0;
            s_d.done = 1'b1;
         end else begin
            s_d.cnt = s_q.cnt - 12'h001;
         end
      end
   end

   // State register.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q <= '{cnt: 12'h000, busy: 1'b0, done: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign done = s_q.done;

endmodule : dpw_phase
`default_nettype wire

// ==== logic/dpw_top.sv ====
// Two-channel pulse-width generator with registers and pin steering.
// How the block works, for the next person to touch it.
//
// Registers. Six words sit at consecutive indices, three per channel: a
// control word, a high period and a low period. Only the defined bits are
// stored. Reserved bits are dropped on write and read back as zero, so a
// careless driver cannot park stray state in them.
//
// Reads. The read data is registered, so a read answers one cycle after the
// index is presented. This keeps the read mux off the output pins' timing
// path. The cost is that a bus master must wait a cycle for its word.
//
// Commands. A control write is stored on the edge that takes it and acted
// on one cycle later. Every control write re-applies its command, even when
// the value is unchanged. Writing the same free-run word twice therefore
// restarts the high phase, which software must keep in mind.
//
// Timing. Both channels share one prescaler, which gives three ticks every
// twenty clocks. Ticks are spaced seven, seven and six clocks apart, so any
// single tick is up to one clock off the ideal. Over three ticks the error
// cancels exactly. The first tick of a freshly loaded phase may fall
// anywhere in its window, so the first phase can run up to one tick short.
// Later phases start right after a tick and run their full length.
//
// Pins. Each enabled channel drives exactly one pin. When both channels
// name the same pin, channel 0 wins and channel 1 is hidden. A disabled
// channel releases its pin but remembers its level, so a later idle command
// resumes from the level it last showed.
//
// Limits. A period of zero is illegal and behaves as one tick. Undefined
// command codes act as idle rather than guessing at a meaning.
`timescale 1ns/10ps
`default_nettype none
module dpw_top (
   input  wire logic        mclk,       // System clock, 25 MHz.
   input  wire logic        arst_n,     // Asynchronous reset, active low.
   input  wire logic [9:0]  reg_addr,   // Register index.
   input  wire logic        reg_wr,     // Write strobe, one cycle.
   input  wire logic [15:0] reg_wdata,  // Write data.
   output var  logic [15:0] reg_rdata,  // Read data for last cycle's index.
   output var  logic [31:0] pin_out,    // Pin output levels.
   output var  logic [31:0] pin_oe      // Pin output enables, high drives.
);

   // All state of this module in one packed record.
   typedef struct packed {
      logic [1:0][8:0]              ctl;    // Control registers.
      logic [1:0][11:0]             hi;     // High period registers.
      logic [1:0][11:0]             lo;     // Low period registers.
      logic [1:0]                   apply;  // Control was written last cycle.
      dpw_pkg::dpw_state_t [1:0]    st;     // Sequencer state per channel.
      logic [1:0]                   lvl;    // Level each channel presents.
      logic [1:0]                   ld;     // Load pulse to phase counter.
      logic [1:0][11:0]             ldv;    // Phase length to load.
      logic [15:0]                  rdata;  // Registered read data.
      logic [31:0]                  pout;   // Registered pin levels.
      logic [31:0]                  poe;    // Registered pin enables.
   } dpw_top_state_t;

   dpw_top_state_t s_q;   // Current state.
   dpw_top_state_t s_d;   // Next state.
   logic           tick;  // Shared tick pulse.
   logic [1:0]     done;  // Phase end pulses.

   // Compares an index with a register offset; used for every decode.
   function automatic logic reg_hit(input logic [9:0] a, input logic [9:0] off);
      reg_hit = (a == off);
   endfunction : reg_hit

   // Control register index of a channel.
   function automatic logic [9:0] ctl_off(input int unsigned ch);
      ctl_off = (ch == 0) ? dpw_pkg::OFF_CH0_CTL : dpw_pkg::OFF_CH1_CTL;
   endfunction : ctl_off

   // High period register index of a channel.
   function automatic logic [9:0] hi_off(input int unsigned ch);
      hi_off = (ch == 0) ? dpw_pkg::OFF_CH0_HIGH : dpw_pkg::OFF_CH1_HIGH;
   endfunction : hi_off

   // Low period register index of a channel.
   function automatic logic [9:0] lo_off(input int unsigned ch);
      lo_off = (ch == 0) ? dpw_pkg::OFF_CH0_LOW : dpw_pkg::OFF_CH1_LOW;
   endfunction : lo_off

   // One prescaler serves both channels so their ticks stay in step.
   dpw_tick u_tick (
      .mclk   (mclk),
      .arst_n (arst_n),
      .tick   (tick)
   );

   // Phase counters, one per channel.
   dpw_phase u_phase0 (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .load     (s_q.ld[0]),
      .load_val (s_q.ldv[0]),
      .tick     (tick),
      .done     (done[0])
   );

   dpw_phase u_phase1 (
      .mclk     (mclk),
      .arst_n   (arst_n),
      .load     (s_q.ld[1]),
      .load_val (s_q.ldv[1]),
      .tick     (tick),
      .done     (done[1])
   );

   // Next-state logic: register writes, read mux, sequencers, pin steering.
   always_comb begin
      logic [2:0] cmd;  // Command field of the channel in hand.
      logic       en;   // Enable bit of the channel in hand.
      logic [4:0] sel;  // Pin selector of the channel in hand.
      cmd = 3'h0;
      en  = 1'b0;
      sel = 5'h00;
      s_d = s_q;

      // Register writes. Only defined bits are stored, so reserved bits
      // read back as zero even if software breaks the write-zero habit.
      for (int unsigned c = 0; c < dpw_pkg::NCH; c++) begin
         s_d.apply[c] = 1'b0;
         if (reg_wr && reg_hit(reg_addr, ctl_off(c))) begin
            s_d.ctl[c]   = reg_wdata[8:0];
            s_d.apply[c] = 1'b1;
         end
         if (reg_wr && reg_hit(reg_addr, hi_off(c))) begin
            s_d.hi[c] = reg_wdata[11:0];
         end
         if (reg_wr && reg_hit(reg_addr, lo_off(c))) begin
            s_d.lo[c] = reg_wdata[11:0];
         end
      end

      // Read mux. Unmapped indices read zero; the answer lands a cycle late.
      s_d.rdata = 16'h0000;
      for (int unsigned c = 0; c < dpw_pkg::NCH; c++) begin
         if (reg_hit(reg_addr, ctl_off(c))) begin
            s_d.rdata = {7'h00, s_q.ctl[c]};
         end
         if (reg_hit(reg_addr, hi_off(c))) begin
            s_d.rdata = {4'h0, s_q.hi[c]};
         end
         if (reg_hit(reg_addr, lo_off(c))) begin
            s_d.rdata = {4'h0, s_q.lo[c]};
         end
      end

      // Channel sequencers. A control write is acted on the cycle after it,
      // when the stored fields already hold the new value.
      for (int unsigned c = 0; c < dpw_pkg::NCH; c++) begin
         cmd       = s_q.ctl[c][dpw_pkg::CMD_MSB:dpw_pkg::CMD_LSB];
         en        = s_q.ctl[c][dpw_pkg::EN_BIT];
         s_d.ld[c] = 1'b0;
         if (!en) begin
            // A disabled channel parks; it keeps its level for a later idle.
            s_d.st[c] = dpw_pkg::ST_HOLD;
         end else if (s_q.apply[c]) begin
            // A fresh command overrides any phase in progress.
            case (cmd)
               dpw_pkg::CMD_IDLE: begin
                  s_d.st[c] = dpw_pkg::ST_HOLD;
               end
               dpw_pkg::CMD_LOW, dpw_pkg::CMD_LOW_ALT: begin
                  s_d.st[c]  = dpw_pkg::ST_LOW;
                  s_d.lvl[c] = 1'b0;
               end
               dpw_pkg::CMD_ONESHOT: begin
                  // Invert the held level; the pulse length is the period
                  // of the level being entered.
                  s_d.st[c]  = dpw_pkg::ST_SHOT;
                  s_d.lvl[c] = ~s_q.lvl[c];
                  s_d.ld[c]  = 1'b1;
                  s_d.ldv[c] = s_q.lvl[c] ? s_q.lo[c] : s_q.hi[c];
               end
               dpw_pkg::CMD_RUN: begin
                  s_d.st[c]  = dpw_pkg::ST_RUN_HI;
                  s_d.lvl[c] = 1'b1;
                  s_d.ld[c]  = 1'b1;
                  s_d.ldv[c] = s_q.hi[c];
               end
               default: begin
                  // Undefined codes are treated as idle, the safest choice.
                  s_d.st[c] = dpw_pkg::ST_HOLD;
               end
            endcase
         end else begin
            case (s_q.st[c])
               dpw_pkg::ST_SHOT: begin
                  if (done[c]) begin
                     s_d.lvl[c] = ~s_q.lvl[c];
                     s_d.st[c]  = dpw_pkg::ST_HOLD;
                  end
               end
               dpw_pkg::ST_RUN_HI: begin
                  // Period values are sampled only at a phase boundary, as here, or on a new command.
                  if (done[c]) begin
                     s_d.lvl[c] = 1'b0;
                     s_d.st[c]  = dpw_pkg::ST_RUN_LO;
                     s_d.ld[c]  = 1'b1;
                     s_d.ldv[c] = s_q.lo[c];
                  end
               end
               dpw_pkg::ST_RUN_LO: begin
                  if (done[c]) begin
                     s_d.lvl[c] = 1'b1;
                     s_d.st[c]  = dpw_pkg::ST_RUN_HI;
                     s_d.ld[c]  = 1'b1;
                     s_d.ldv[c] = s_q.hi[c];
                  end
               end
               dpw_pkg::ST_LOW: begin
                  s_d.lvl[c] = 1'b0;
               end
               default: begin
                  // Hold: no new transitions.
                  s_d.lvl[c] = s_q.lvl[c];
               end
            endcase
         end
      end

      // Pin steering. Channel 0 is applied last, so it wins a shared pin.
      s_d.pout = 32'h0000_0000;
      s_d.poe  = 32'h0000_0000;
      for (int c = dpw_pkg::NCH - 1; c >= 0; c--) begin
         en  = s_q.ctl[c][dpw_pkg::EN_BIT];
         sel = s_q.ctl[c][dpw_pkg::PIN_MSB:0];
         if (en) begin
            s_d.poe[sel]  = 1'b1;
            s_d.pout[sel] = s_q.lvl[c];
         end
      end
   end

   // State register; reset values as the register map gives them.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         s_q.ctl   <= {dpw_pkg::CTL_RST, dpw_pkg::CTL_RST};
         s_q.hi    <= {dpw_pkg::PERIOD_RST, dpw_pkg::PERIOD_RST};
         s_q.lo    <= {dpw_pkg::PERIOD_RST, dpw_pkg::PERIOD_RST};
         s_q.apply <= 2'h0;
         s_q.st    <= '{dpw_pkg::ST_HOLD, dpw_pkg::ST_HOLD};
         s_q.lvl   <= 2'h0;
         s_q.ld    <= 2'h0;
         s_q.ldv   <= 24'h000000;
         s_q.rdata <= 16'h0000;
         s_q.pout  <= 32'h0000_0000;
         s_q.poe   <= 32'h0000_0000;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register.
   assign reg_rdata = s_q.rdata;
   assign pin_out   = s_q.pout;
   assign pin_oe    = s_q.poe;

endmodule : dpw_top
`default_nettype wire

// ==== sim/dpw_top_monitor.sv ====
// Checker for the pulse generator's register and pin ports.
`timescale 1ns/10ps
`default_nettype none
module dpw_top_monitor (
   input wire logic        mclk,       // Clock.
   input wire logic        arst_n,     // Reset, active low.
   input wire logic [9:0]  reg_addr,   // Register index.
   input wire logic        reg_wr,     // Write strobe.
   input wire logic [15:0] reg_wdata,  // Write data.
   input wire logic [15:0] reg_rdata,  // Read data.
   input wire logic [31:0] pin_out,    // Pin levels.
   input wire logic [31:0] pin_oe      // Pin enables.
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // A write to the channel 0 control word.
   wire c0w = reg_wr && reg_addr == dpw_pkg::OFF_CH0_CTL;
   logic [4:0] c0_pin_q;  // Pin named by the latest channel 0 control write.
   // Remembering the pin lets later checks look at exactly that pin.
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         c0_pin_q <= 5'h00;
      end else if (c0w) begin
         c0_pin_q <= reg_wdata[4:0];
      end
   end
   a_reset_quiet: assert property (arst_n && !$past(arst_n) |-> pin_oe == 32'h0 && reg_rdata == 16'h0)
      else $error("outputs not quiet after reset");
   a_oe_limit: assert property ($countones(pin_oe) <= 2)
      else $error("more than two pins driven");
   a_out_gated: assert property ((pin_out & ~pin_oe) == 32'h0)
      else $error("level shown on an undriven pin");
   a_unmapped_zero: assert property (reg_addr < dpw_pkg::OFF_CH0_CTL || reg_addr > dpw_pkg::OFF_CH1_LOW
      |=> reg_rdata == 16'h0000) else $error("unmapped index read nonzero");
   a_reserved_zero: assert property (reg_addr == dpw_pkg::OFF_CH0_CTL || reg_addr == dpw_pkg::OFF_CH1_CTL
      |=> reg_rdata[15:9] == 7'h00) else $error("reserved control bits read nonzero");
   a_ctl_readback: assert property (c0w ##1 (!reg_wr && reg_addr == dpw_pkg::OFF_CH0_CTL)
      |=> reg_rdata == {7'h00, $past(reg_wdata[8:0], 2)}) else $error("control word not stored");
   a_period_readback: assert property ((reg_wr && reg_addr == dpw_pkg::OFF_CH0_HIGH)
      ##1 (!reg_wr && reg_addr == dpw_pkg::OFF_CH0_HIGH) |=> reg_rdata == {4'h0, $past(reg_wdata[11:0], 2)})
      else $error("high period not stored");
   a_low_cmd: assert property (c0w && reg_wdata[5] && (reg_wdata[8:6] == 3'b100 || reg_wdata[8:6] == 3'b111)
      ##1 !reg_wr [*2] |=> pin_oe[c0_pin_q] && !pin_out[c0_pin_q]) else $error("low command not driving low");
   a_run_high: assert property (c0w && reg_wdata[5] && reg_wdata[8:6] == 3'b110 ##1 !reg_wr [*2]
      |=> pin_oe[c0_pin_q] && pin_out[c0_pin_q]) else $error("free run not starting high");
   a_idle_holds: assert property (c0w && reg_wdata[5] && reg_wdata[8:6] == 3'b000 ##1 !reg_wr [*5]
      |=> $stable(pin_out[c0_pin_q])) else $error("idle pin changed level");
endmodule : dpw_top_monitor
bind dpw_top dpw_top_monitor mon (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe));
`default_nettype wire

// ==== sim/dpw_pin_load.sv ====
// Load on one generator pin: resolves its level and times its phases.
`timescale 1ns/10ps
`default_nettype none
module dpw_pin_load (
   input  wire logic        mclk,     // System clock.
   input  wire logic [31:0] pin_out,  // Levels from the generator.
   input  wire logic [31:0] pin_oe,   // Enables from the generator.
   input  wire logic [4:0]  watch,    // Observed pin.
   input  wire logic        clr,      // Clears the edge count.
   output var  logic        level,    // Resolved pin level.
   output var  logic [15:0] hi_cyc,   // Last finished high phase, cycles.
   output var  logic [15:0] lo_cyc,   // Last finished low phase, cycles.
   output var  logic [7:0]  edges     // Transitions since clear.
);
   logic [15:0] run_cyc = 16'h0001;  // Cycles in the running phase.
   logic        prev    = 1'b1;      // Level one cycle ago.
   // A released pin floats up to its pull-up, so it never shows a stale level.
   always_comb begin
      level = pin_oe[watch] ? pin_out[watch] : 1'b1;
   end
   // A level change closes the running phase and records its length.
   always @(posedge mclk) begin
      prev <= level;
      if (clr) begin
         edges   <= 8'h00;
         run_cyc <= 16'h0001;
      end else if (level !== prev) begin
         if (prev) begin
            hi_cyc <= run_cyc;
         end else begin
            lo_cyc <= run_cyc;
         end
         run_cyc <= 16'h0001;
         edges   <= edges + 8'h01;
      end else begin
         run_cyc <= run_cyc + 16'h0001;
      end
   end
endmodule : dpw_pin_load
`default_nettype wire

// ==== sim/tb_dpw_top.sv ====
// Self-checking bench for the dual pulse-width pin generator.
`timescale 1ns/10ps
`default_nettype none
module tb_dpw_top;
   logic        mclk      = 1'b0;      // System clock.
   logic        arst_n    = 1'b0;      // Reset, active low.
   logic [9:0]  reg_addr  = 10'h000;   // Register index.
   logic        reg_wr    = 1'b0;      // Write strobe.
   logic [15:0] reg_wdata = 16'h0000;  // Write data.
   logic [15:0] reg_rdata;             // Read data.
   logic [31:0] pin_out;               // Pin levels.
   logic [31:0] pin_oe;                // Pin enables.
   logic [4:0]  watch     = 5'h00;     // Observed pin.
   logic        clr       = 1'b0;      // Clears the load's count.
   logic        level;                 // Observed pin level.
   logic [15:0] hi_cyc;                // Last high phase.
   logic [15:0] lo_cyc;                // Last low phase.
   logic [7:0]  edges;                 // Edges since clear.
   logic [15:0] rd_val;                // Word from a read.
   int          err_total  = 0;        // Mismatches.
   int          num_checks = 0;        // Comparisons.
   int          i;                     // Loop index.
   // 25 MHz clock.
   always #20 mclk = ~mclk;
   dpw_top uut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pin_out(pin_out), .pin_oe(pin_oe));
   dpw_pin_load load (.mclk(mclk), .pin_out(pin_out), .pin_oe(pin_oe), .watch(watch), .clr(clr),
      .level(level), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc), .edges(edges));
   // One write; the strobe drops on the edge that takes it.
   task automatic wr(input logic [9:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wr    <= 1'b1;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : wr
   // Presents an index and takes the word shown one cycle later.
   task automatic rd(input logic [9:0] a, output logic [15:0] d);
      @(posedge mclk);
      reg_addr <= a;
      @(posedge mclk);
      #1;
      d = reg_rdata;
   endtask : rd
   // Waits whole cycles, then lets the edge's updates land.
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : settle
   // Points the load at a pin and clears its count.
   task automatic observe(input logic [4:0] p);
      @(posedge mclk);
      watch <= p;
      clr   <= 1'b1;
      @(posedge mclk);
      clr <= 1'b0;
   endtask : observe
   // Exact comparison; an unknown never matches.
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("wrong value %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   // Window comparison for measured phase lengths.
   task automatic chk_rng(input string n, input int lo, input int hi, input logic [15:0] g);
      logic ok;
      ok = (g >= lo) && (g <= hi);
      num_checks++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("wrong value %s: expected %0d..%0d, seen %0d", n, lo, hi, g);
      end
   endtask : chk_rng
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish;
      $display("checks %0d, mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : tally_and_finish
   // A hang counts as a mismatch.
   initial begin
      repeat (5000) @(posedge mclk);
      err_total++;
      tally_and_finish;
   end
   // Tests. A phase of N ticks is N*20/3 cycles once it starts on a tick.
   initial begin
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      for (i = 0; i < 6; i++) begin
         rd(10'(dpw_pkg::OFF_CH0_CTL + i), rd_val);
         chk("reset value", (i % 3 == 0) ? 32'h0 : 32'h1, {16'h0, rd_val});
      end
      rd(10'h3d7, rd_val);
      chk("unmapped below", 32'h0, {16'h0, rd_val});
      rd(10'h3de, rd_val);
      chk("unmapped above", 32'h0, {16'h0, rd_val});
      for (i = 0; i < 6; i++) begin
         wr(10'(dpw_pkg::OFF_CH0_CTL + i), 16'hffff);
         rd(10'(dpw_pkg::OFF_CH0_CTL + i), rd_val);
         chk("reserved bits", (i % 3 == 0) ? 32'h1ff : 32'hfff, {16'h0, rd_val});
      end
      chk("code 111 pin", 32'h8000_0000, pin_oe);
      chk("code 111 level", 32'h0, pin_out);
      wr(dpw_pkg::OFF_CH1_CTL, 16'h0000);
      for (i = 0; i < 32; i++) begin
         wr(dpw_pkg::OFF_CH0_CTL, 16'(16'h0120 + i));
         settle(4);
         chk("pin select", 32'h1 << i, pin_oe);
         chk("code 100 level", 32'h0, pin_out);
      end
      observe(5'd5);
      wr(dpw_pkg::OFF_CH0_HIGH, 16'h0003);
      wr(dpw_pkg::OFF_CH0_LOW, 16'h0006);
      wr(dpw_pkg::OFF_CH0_CTL, 16'h01a5);
      settle(150);
      chk_rng("ch0 high", 19, 21, hi_cyc);
      chk_rng("ch0 low", 39, 41, lo_cyc);
      wr(dpw_pkg::OFF_CH0_HIGH, 16'h0006);
      settle(150);
      chk_rng("ch0 new high", 39, 41, hi_cyc);
      observe(5'd9);
      wr(dpw_pkg::OFF_CH1_HIGH, 16'h0006);
      wr(dpw_pkg::OFF_CH1_LOW, 16'h0003);
      wr(dpw_pkg::OFF_CH1_CTL, 16'h01a9);
      settle(150);
      chk_rng("ch1 high", 39, 41, hi_cyc);
      chk_rng("ch1 low", 19, 21, lo_cyc);
      wr(dpw_pkg::OFF_CH0_CTL, 16'h0185);
      wr(dpw_pkg::OFF_CH1_CTL, 16'h0189);
      settle(4);
      chk("disabled pins", 32'h0, pin_oe);
      wr(dpw_pkg::OFF_CH0_CTL, 16'h012c);
      observe(5'd12);
      wr(dpw_pkg::OFF_CH0_HIGH, 16'h0003);
      wr(dpw_pkg::OFF_CH0_CTL, 16'h016c);
      settle(60);
      chk("shot edges", 32'h2, {24'h0, edges});
      chk("shot rest", 32'h0, {31'h0, level});
      chk_rng("shot high", 12, 24, hi_cyc);
      wr(dpw_pkg::OFF_CH0_HIGH, 16'h0006);
      wr(dpw_pkg::OFF_CH0_CTL, 16'h01ac);
      for (i = 0; i < 100 && level !== 1'b1; i++) settle(1);
      wr(dpw_pkg::OFF_CH0_CTL, 16'h002c);
      settle(60);
      chk("idle keeps high", 32'h1, {31'h0, level});
      observe(5'd12);
      wr(dpw_pkg::OFF_CH0_LOW, 16'h0003);
      wr(dpw_pkg::OFF_CH0_CTL, 16'h016c);
      settle(60);
      chk("low shot edges", 32'h2, {24'h0, edges});
      chk("low shot rest", 32'h1, {31'h0, level});
      chk_rng("low shot", 12, 24, lo_cyc);
      tally_and_finish;
   end
endmodule : tb_dpw_top
`default_nettype wire
